// *** rtl/branch_debug_control.sv ***
`timescale 1ns/1ns
`default_nettype none
module branch_debug_control (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // register access port
  input  wire logic [11:0] regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [63:0] regWdata,
  output logic      [63:0] regRdata,
  output logic             regHit,
  // core state
  input  wire logic [1:0]  privilegeLevel,
  input  wire logic        stepFlag,
  input  wire logic        debugCtlTxDbg,
  input  wire logic        inTransaction,
  input  wire logic        threadFeedbackEn,
  // core events
  input  wire logic        branchTaken,
  input  wire logic        intOrExc,
  input  wire logic        debugExcRaise,
  input  wire logic        breakpointRaise,
  input  wire logic        insnRetire,
  input  wire logic        busLockSeen,
  input  wire logic        storeFull,
  input  wire logic        perfMonitorIrq,
  input  wire logic        managementIrq,
  input  wire logic        managementResume,
  // actions
  output logic             recordPush,
  output logic             recordFrozen,
  output logic             counterFreeze,
  output logic             counterEnableClear,
  output logic             counterEnableSet,
  output logic             stepTrap,
  output logic             lockTrap,
  output logic             lockStatusClear,
  output logic             msgSend,
  output logic             storeLog,
  output logic             storeCircular,
  output logic             storeFullIrq,
  output logic             txAbort,
  output logic             abortStatusDbg,
  output logic             resumeAtBegin,
  output logic             resumeAtFallback,
  output logic             debugExcDeliver,
  output logic             breakpointDeliver,
  output logic             debugStatusTxSet,
  output logic             debugStatusTxClr,
  output logic             historyReset
);
  logic [63:0] ctl;
  logic [63:0] saved;
  logic        kernelMode;
  logic        traceEvent;
  logic        advDebug;
  logic        excEvent;
  logic        txExc;
  logic        plainDbg;
  logic        writeHit;
  logic        mgmtEntry;
  logic        frozen;
  logic        stepHit;
  logic        lockHit;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign kernelMode = (privilegeLevel == 2'h0);
  assign writeHit   = regWrite && (regAddr == branch_debug_pkg::CTL_ADDR); // RULE6
  assign regHit     = (regWrite || regRead) && (regAddr == branch_debug_pkg::CTL_ADDR);
  assign mgmtEntry  = managementIrq && ctl[branch_debug_pkg::B_MGMTFRZ];
  assign excEvent   = debugExcRaise || breakpointRaise || stepHit || lockHit; // RULE1
  assign txExc      = excEvent && inTransaction;
  assign advDebug   = debugCtlTxDbg && ctl[branch_debug_pkg::B_TXDBG]; // RULE3

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // hardware side effects take priority over software writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= branch_debug_pkg::CTL_RESET;
    end else if (managementResume) begin
      ctl <= saved; // RULE18
    end else if (mgmtEntry) begin
      ctl <= ctl & ~branch_debug_pkg::MGMT_CLR_MASK; // RULE17
    end else if (debugExcDeliver) begin
      ctl[branch_debug_pkg::B_RECORD] <= 1'b0; // RULE20 RULE21
      ctl[branch_debug_pkg::B_STEP]   <= 1'b0;
    end else if (writeHit) begin
      ctl <= regWdata & branch_debug_pkg::CTL_MASK; // RULE24
    end
  end

  // saved copy for management mode
  save_reg #(
    .W (branch_debug_pkg::REG_W)
  ) u_save (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .load    (mgmtEntry), // RULE17
    .din     (ctl),
    .dout    (saved)
  );

  // read data from flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 64'h0000000000000000;
    end else if (regRead) begin
      regRdata <= (regAddr == branch_debug_pkg::CTL_ADDR) ? ctl : 64'h0000000000000000;
    end
  end

  // ------------------------------------------------------------
  // record stack and counters
  // ------------------------------------------------------------
  // freeze held until software rewrites the register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frozen <= 1'b0;
    end else if (perfMonitorIrq && ctl[branch_debug_pkg::B_RECFRZ]) begin
      frozen <= 1'b1; // RULE15
    end else if (writeHit) begin
      frozen <= 1'b0;
    end
  end
  assign recordFrozen = frozen;
  assign traceEvent   = branchTaken || intOrExc;
  // record stack keeps updating while messages enabled
  assign recordPush   = traceEvent && !debugExcRaise && !frozen
                        && (ctl[branch_debug_pkg::B_RECORD] || ctl[branch_debug_pkg::B_MSG]); // RULE7 RULE21
  assign counterFreeze      = perfMonitorIrq && ctl[branch_debug_pkg::B_CNTFRZ]; // RULE16
  assign counterEnableClear = mgmtEntry; // RULE17
  assign counterEnableSet   = managementResume; // RULE18
  assign historyReset       = threadFeedbackEn && (mgmtEntry || managementResume); // RULE19

  // ------------------------------------------------------------
  // stepping and lock detection
  // ------------------------------------------------------------
  // raw trap conditions; inside a transaction they abort instead of trapping
  assign stepHit  = stepFlag
                    && (ctl[branch_debug_pkg::B_STEP] ? branchTaken : insnRetire); // RULE8
  assign lockHit  = busLockSeen && ctl[branch_debug_pkg::B_LOCK] && !kernelMode; // RULE9
  assign stepTrap = stepHit && !inTransaction; // RULE1
  assign lockTrap = lockHit && !inTransaction; // RULE1 RULE23
  assign lockStatusClear = lockTrap; // RULE23

  // ------------------------------------------------------------
  // trace messages and store
  // ------------------------------------------------------------
  trace_filter u_filter (
    .msgEn      (ctl[branch_debug_pkg::B_MSG]),
    .storeEn    (ctl[branch_debug_pkg::B_STORE]),
    .skipKernel (ctl[branch_debug_pkg::B_SKIPK]),
    .skipUser   (ctl[branch_debug_pkg::B_SKIPU]),
    .kernelMode (kernelMode),
    .traceEvent (traceEvent),
    .msgSend    (msgSend),
    .storeLog   (storeLog)
  );
  assign storeCircular = ctl[branch_debug_pkg::B_STORE] && !ctl[branch_debug_pkg::B_FULLIRQ]; // RULE12
  assign storeFullIrq  = storeFull && ctl[branch_debug_pkg::B_STORE]
                         && ctl[branch_debug_pkg::B_FULLIRQ]; // RULE12

  // ------------------------------------------------------------
  // transactional exceptions
  // ------------------------------------------------------------
  assign txAbort          = txExc; // RULE1 RULE2
  assign abortStatusDbg   = txExc; // RULE1
  assign resumeAtBegin    = txExc && advDebug; // RULE3
  assign resumeAtFallback = txExc && !advDebug; // RULE2
  assign plainDbg         = debugExcRaise && !inTransaction;
  assign debugExcDeliver  = plainDbg || lockTrap || stepTrap || (txExc && advDebug); // RULE4
  assign breakpointDeliver = breakpointRaise && !inTransaction; // RULE1
  assign debugStatusTxClr = txExc && advDebug; // RULE5
  assign debugStatusTxSet = debugExcDeliver && !(txExc && advDebug); // RULE5
endmodule : branch_debug_control
`default_nettype wire

// *** rtl/branch_debug_pkg.sv ***
// What this block does
// RULE1: debug or breakpoint inside transaction aborts, sets abort status bit 4, no exception.
// RULE2: abort discards region updates, restores state, resumes at fallback address.
// RULE3: both transaction debug enables set: resume at begin insn, deliver debug exception.
// RULE4: advanced mode delivers debug exception even when a breakpoint caused abort.
// RULE5: transactional debug exception clears status bit 16; all others set it.
// RULE6: control register sits at address 01D9H.
// RULE7: bit 0 records branches, interrupts, exceptions except debug exceptions.
// RULE8: bit 1 makes step flag step on taken branches.
// RULE9: bit 2 enables lock detection only above privilege level 0.
// RULE10: bit 6 sends a branch message per branch, interrupt or exception.
// RULE11: bit 7 logs branch messages into the memory store.
// RULE12: bit 8 raises interrupt on full store; clear means circular logging.
// RULE13: bit 9 skips store and messages at privilege level 0.
// RULE14: bit 10 skips store and messages above privilege level 0.
// RULE15: bit 11 freezes record stack on counter interrupt.
// RULE16: bit 12 freezes all performance counters on counter interrupt.
// RULE17: bit 14 on management irq clears counter enables, saves, disables trace fields.
// RULE18: management resume sets counter enables and restores saved register copy.
// RULE19: enabled scheduling feedback history resets on management entry and resume.
// RULE20: debug exception clears record enable, keeps stored entries.
// RULE21: debug exception leaves message enable unchanged.
// RULE22: software checks capability bit 12 before using management freeze.
// RULE23: lock detection debug exception clears lock indication; trap after locking insn.
// RULE24: undefined bits read zero and ignore writes.
package branch_debug_pkg;
  localparam logic [11:0] CTL_ADDR      = 12'h1D9; // RULE6
  localparam int          REG_W         = 64;
  localparam logic [63:0] CTL_RESET     = 64'h0000000000000000;
  localparam logic [63:0] CTL_MASK      = 64'h000000000000DFC7; // RULE24
  localparam int          B_RECORD      = 0;
  localparam int          B_STEP        = 1;
  localparam int          B_LOCK        = 2;
  localparam int          B_MSG         = 6;
  localparam int          B_STORE       = 7;
  localparam int          B_FULLIRQ     = 8;
  localparam int          B_SKIPK       = 9;
  localparam int          B_SKIPU       = 10;
  localparam int          B_RECFRZ      = 11;
  localparam int          B_CNTFRZ      = 12;
  localparam int          B_MGMTFRZ     = 14;
  localparam int          B_TXDBG       = 15;
  localparam int          DCTL_TXDBG    = 11;
  localparam int          DSTAT_TX      = 16;
  localparam int          ABORT_DBG     = 4;
  localparam logic [63:0] MGMT_CLR_MASK = 64'h00000000000000C3; // record, step, msg, store
endpackage : branch_debug_pkg

// *** rtl/save_reg.sv ***
`timescale 1ns/1ns
`default_nettype none
module save_reg #(
  parameter int W = 64
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // load
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  // held copy
  output logic      [W-1:0] dout
);
  // holding register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout <= '0;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule : save_reg
`default_nettype wire

// *** rtl/trace_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module trace_filter (
  // controls
  input  wire logic msgEn,
  input  wire logic storeEn,
  input  wire logic skipKernel,
  input  wire logic skipUser,
  input  wire logic kernelMode,
  // event
  input  wire logic traceEvent,
  // qualified outputs
  output logic      msgSend,
  output logic      storeLog
);
  logic allowed;
  // privilege qualification
  assign allowed  = !(skipKernel && kernelMode) && !(skipUser && !kernelMode); // RULE13 RULE14
  assign msgSend  = traceEvent && msgEn && allowed;   // RULE10
  assign storeLog = traceEvent && storeEn && allowed; // RULE11
endmodule : trace_filter
`default_nettype wire

// *** tb/branch_debug_control_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module branch_debug_control_asserts (
  // clock, reset, register port
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [11:0] regAddr,
  input wire logic        regRead,
  input wire logic        regWrite,
  input wire logic [63:0] regRdata,
  input wire logic        regHit,
  // core state and events
  input wire logic [1:0]  privilegeLevel,
  input wire logic        debugCtlTxDbg,
  input wire logic        inTransaction,
  input wire logic        threadFeedbackEn,
  input wire logic        debugExcRaise,
  input wire logic        breakpointRaise,
  input wire logic        managementIrq,
  input wire logic        managementResume,
  // actions
  input wire logic        lockTrap,
  input wire logic        txAbort,
  input wire logic        abortStatusDbg,
  input wire logic        resumeAtFallback,
  input wire logic        debugExcDeliver,
  input wire logic        breakpointDeliver,
  input wire logic        debugStatusTxSet,
  input wire logic        debugStatusTxClr,
  input wire logic        counterEnableClear,
  input wire logic        counterEnableSet,
  input wire logic        historyReset
);
  // one clock domain for every check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_HIT: assert property ((regRead || regWrite) && regAddr == 12'h1D9 |-> regHit)
    else $error("register hit missing");
  AST_HOLD: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (regRead && regAddr != 12'h1D9 |=> regRdata == 64'h0)
    else $error("unmapped read not zero");
  AST_LOCK_KERNEL: assert property (privilegeLevel == 2'h0 |-> !lockTrap)
    else $error("lock trap at level zero");
  AST_TX_PLAIN: assert property (
    !debugCtlTxDbg && inTransaction && (debugExcRaise || breakpointRaise)
    |-> txAbort && abortStatusDbg && resumeAtFallback && !debugExcDeliver && !breakpointDeliver)
    else $error("plain transactional abort wrong");
  AST_STATUS: assert property (debugStatusTxClr |-> debugExcDeliver && inTransaction && !debugStatusTxSet)
    else $error("status bit clear without transactional delivery");
  AST_ENSET: assert property (counterEnableSet == managementResume)
    else $error("counter enable set out of step with resume");
  AST_ENCLR: assert property (counterEnableClear |-> managementIrq)
    else $error("counter enable clear without management irq");
  AST_HIST: assert property (historyReset |-> threadFeedbackEn && (managementIrq || managementResume))
    else $error("history reset out of place");
  // main scenarios reached
  cover property (debugStatusTxClr);
  cover property (counterEnableSet);
  cover property (txAbort && abortStatusDbg);
endmodule : branch_debug_control_asserts
bind branch_debug_control branch_debug_control_asserts u_chk (.*);
`default_nettype wire

// *** tb/branch_debug_control_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module branch_debug_control_test;
  logic        ref_clk, rst_b, regWrite, regRead, regHit, stepFlag, debugCtlTxDbg;
  logic        inTransaction, threadFeedbackEn, branchTaken, intOrExc, debugExcRaise;
  logic        breakpointRaise, insnRetire, busLockSeen, storeFull, perfMonitorIrq;
  logic        managementIrq, managementResume, recordPush, recordFrozen, counterFreeze;
  logic        counterEnableClear, counterEnableSet, stepTrap, lockTrap, lockStatusClear;
  logic        msgSend, storeLog, storeCircular, storeFullIrq, txAbort, abortStatusDbg;
  logic        resumeAtBegin, resumeAtFallback, debugExcDeliver, breakpointDeliver;
  logic        debugStatusTxSet, debugStatusTxClr, historyReset, e;
  logic [1:0]  privilegeLevel;
  logic [9:0]  ev;
  logic [11:0] regAddr;
  logic [63:0] regWdata, regRdata, c;
  int          checks, nFail;
  assign {managementResume, managementIrq, perfMonitorIrq, storeFull, busLockSeen, insnRetire,
          breakpointRaise, debugExcRaise, intOrExc, branchTaken} = ev;
  branch_debug_control u_branch_debug_control (.*);
  // free running clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [63:0] d);
    @(posedge ref_clk) begin regAddr <= 12'h1D9; regWdata <= d; regWrite <= 1'b1; end
    @(posedge ref_clk) regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [63:0] x);
    @(posedge ref_clk) begin regAddr <= a; regRead <= 1'b1; end
    @(posedge ref_clk) regRead <= 1'b0;
    @(negedge ref_clk) chk("readback", x, regRdata);
  endtask : rd
  task automatic fire(input logic [9:0] m);
    @(posedge ref_clk) ev <= m;
    @(negedge ref_clk);
  endtask : fire
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // hang guard
  initial begin
    repeat (3000) @(posedge ref_clk);
    nFail++;
    tally_and_finish();
  end
  // test sequence
  initial begin
    {rst_b, regWrite, regRead, stepFlag, debugCtlTxDbg, inTransaction} = '0;
    {threadFeedbackEn, privilegeLevel, ev, regAddr, regWdata} = '0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(12'h1D9, 64'h0);
    wr(~64'h0); rd(12'h1D9, 64'hDFC7);
    rd(12'h1DA, 64'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      c = (i < 2) ? 64'h0C4 : (i < 4) ? 64'h2C4 : 64'h4C4;
      wr(c);
      privilegeLevel <= i[0] ? 2'h3 : 2'h0;
      e = !(c[9] && !i[0]) && !(c[10] && i[0]);
      fire(10'h021);
      chk("msgSend", e, msgSend);
      chk("storeLog", e, storeLog);
      chk("lockTrap", i[0], lockTrap);
      chk("lockStatusClear", i[0], lockStatusClear);
      fire(10'h000);
    end
    @(posedge ref_clk) privilegeLevel <= 2'h0;
    wr(64'h43);
    fire(10'h001); chk("recordPush", 1, recordPush);
    fire(10'h006); chk("debugExcDeliver", 1, debugExcDeliver);
    chk("debugStatusTxSet", 1, debugStatusTxSet);
    chk("recordPush", 0, recordPush);
    fire(10'h000); rd(12'h1D9, 64'h40);
    wr(64'h42); stepFlag <= 1'b1;
    fire(10'h010); chk("stepTrap", 0, stepTrap);
    fire(10'h011); chk("stepTrap", 1, stepTrap);
    fire(10'h010); chk("stepTrap", 1, stepTrap);
    fire(10'h000);
    @(posedge ref_clk) stepFlag <= 1'b0;
    fire(10'h008); chk("breakpointDeliver", 1, breakpointDeliver);
    chk("txAbort", 0, txAbort);
    fire(10'h000);
    $display("test debug done");
    @(posedge ref_clk) inTransaction <= 1'b1;
    fire(10'h008); chk("abortStatusDbg", 1, abortStatusDbg);
    chk("txAbort", 1, txAbort);
    chk("resumeAtFallback", 1, resumeAtFallback);
    fire(10'h000); wr(64'h8000); debugCtlTxDbg <= 1'b1;
    fire(10'h008); chk("debugExcDeliver", 1, debugExcDeliver);
    chk("breakpointDeliver", 0, breakpointDeliver);
    chk("resumeAtBegin", 1, resumeAtBegin);
    chk("debugStatusTxClr", 1, debugStatusTxClr);
    fire(10'h000);
    @(posedge ref_clk) {inTransaction, debugCtlTxDbg} <= '0;
    $display("test transaction done");
    wr(64'h48C3); threadFeedbackEn <= 1'b1; // capability taken as present
    fire(10'h100); chk("counterEnableClear", 1, counterEnableClear);
    chk("historyReset", 1, historyReset);
    fire(10'h000); rd(12'h1D9, 64'h4800);
    fire(10'h200); chk("counterEnableSet", 1, counterEnableSet);
    chk("historyReset", 1, historyReset);
    fire(10'h000); rd(12'h1D9, 64'h48C3);
    fire(10'h080); chk("counterFreeze", 0, counterFreeze);
    fire(10'h000); chk("recordFrozen", 1, recordFrozen);
    fire(10'h001); chk("recordPush", 0, recordPush);
    fire(10'h000); wr(64'h1180);
    fire(10'h0C0); chk("counterFreeze", 1, counterFreeze);
    chk("storeFullIrq", 1, storeFullIrq);
    chk("storeCircular", 0, storeCircular);
    fire(10'h000); wr(64'h80);
    @(negedge ref_clk) chk("storeCircular", 1, storeCircular);
    $display("test management and freeze done");
    tally_and_finish();
  end
endmodule : branch_debug_control_test
`default_nettype wire
